// ==== design/msl_strap_loader.v ====
`timescale 1ns/100ps
`include "msl_consts.vh"

// What this block does
// - Capture mode straps when pin reset releases and hold them as configuration.
// - The latched five-bit code picks one operating mode for all ports.
// - Code 01000 enters software power-down with the PLL still running.
// - 01010 forces gigabit full-duplex master, 01011 forces 100 full; negotiation, crossover, EEE off.
// - No strap-selected mode ever advertises gigabit half duplex.
module msl_strap_loader #(
	parameter ADDR_W = 8
) (
	input wire hclk,
	input wire hresetn,
	input wire ce,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	input wire pin_reset_n,
	input wire [`MSL_MODE_W-1:0] mode_strap,
	output reg [`MSL_MODE_W-1:0] mode_code,
	output reg config_valid,
	output reg mode_unsupported,
	output reg sw_power_down,
	output reg pll_enable,
	output reg autoneg_enable,
	output reg auto_crossover,
	output reg energy_efficient_operation,
	output reg forced_gig_full_duplex,
	output reg forced_fast_full_duplex,
	output reg forced_master,
	output reg adv_gig_full_duplex,
	output reg adv_gig_half_duplex,
	output reg adv_fast_full_duplex,
	output reg adv_fast_half_duplex,
	output reg adv_ten_full_duplex,
	output reg adv_ten_half_duplex,
	output reg multi_port
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and release detection.
	reg prst_s1_reg;
	reg prst_s2_reg;
	reg prst_s3_reg;
	reg [`MSL_MODE_W-1:0] strap_s1_reg;
	reg [`MSL_MODE_W-1:0] strap_s2_reg;
	wire release_pulse;

	// The straps are sampled through the same two stages as the reset pin, so the
	// captured code is the level present in the same cycle the released pin was sampled.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prst_s1_reg <= 1'b0;
			prst_s2_reg <= 1'b0;
			prst_s3_reg <= 1'b0;
			strap_s1_reg <= `MSL_MODE_RST;
			strap_s2_reg <= `MSL_MODE_RST;
		end else if (ce) begin
			prst_s1_reg <= pin_reset_n;
			prst_s2_reg <= prst_s1_reg;
			prst_s3_reg <= prst_s2_reg;
			strap_s1_reg <= mode_strap;
			strap_s2_reg <= strap_s1_reg;
		end
	end

	assign release_pulse = prst_s2_reg & ~prst_s3_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Decoder.
	wire dec_pd;
	wire dec_pll;
	wire dec_an;
	wire dec_xover;
	wire dec_eee;
	wire dec_fgig;
	wire dec_ffast;
	wire dec_master;
	wire dec_agfd;
	wire dec_aghd;
	wire dec_affd;
	wire dec_afhd;
	wire dec_atfd;
	wire dec_athd;
	wire dec_multi;
	wire dec_unsup;

	msl_mode_decode u_decode (
		.mode_code(strap_s2_reg),
		.power_down(dec_pd),
		.pll_enable(dec_pll),
		.autoneg_enable(dec_an),
		.auto_crossover(dec_xover),
		.energy_efficient_operation(dec_eee),
		.forced_gig_full_duplex(dec_fgig),
		.forced_fast_full_duplex(dec_ffast),
		.forced_master(dec_master),
		.adv_gig_full_duplex(dec_agfd),
		.adv_gig_half_duplex(dec_aghd),
		.adv_fast_full_duplex(dec_affd),
		.adv_fast_half_duplex(dec_afhd),
		.adv_ten_full_duplex(dec_atfd),
		.adv_ten_half_duplex(dec_athd),
		.multi_port(dec_multi),
		.unsupported(dec_unsup)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus address phase.
	reg wr_pend_reg;
	reg [ADDR_W-1:0] wr_addr_reg;
	wire addr_take;
	wire wr_ctrl;
	reg [31:0] rd_next;
	reg pd_fwd;

	assign addr_take = hsel & hready & htrans[1];
	assign wr_ctrl = ce & wr_pend_reg & (wr_addr_reg == `MSL_OFS_CONTROL);

	// A read right behind a write to control sees the new value, not the stale one.
	always @* begin
		pd_fwd = sw_power_down;
		if (wr_ctrl) begin
			pd_fwd = hwdata[`MSL_CTL_PWRDN];
		end
		if (release_pulse) begin
			pd_fwd = dec_pd;
		end
		rd_next = 32'h00000000;
		case (haddr[ADDR_W-1:0])
			`MSL_OFS_STATUS: begin
				rd_next[`MSL_STS_MODE_LSB +: `MSL_MODE_W] = mode_code;
				rd_next[`MSL_STS_VALID] = config_valid;
				rd_next[`MSL_STS_UNSUP] = mode_unsupported;
				rd_next[`MSL_STS_PINRST] = prst_s2_reg;
			end
			`MSL_OFS_SETTINGS: begin
				rd_next[`MSL_SET_PLL] = pll_enable;
				rd_next[`MSL_SET_AN] = autoneg_enable;
				rd_next[`MSL_SET_XOVER] = auto_crossover;
				rd_next[`MSL_SET_EEE] = energy_efficient_operation;
				rd_next[`MSL_SET_FGIG] = forced_gig_full_duplex;
				rd_next[`MSL_SET_FFAST] = forced_fast_full_duplex;
				rd_next[`MSL_SET_MASTER] = forced_master;
				rd_next[`MSL_SET_AGFD] = adv_gig_full_duplex;
				rd_next[`MSL_SET_AGHD] = adv_gig_half_duplex;
				rd_next[`MSL_SET_AFFD] = adv_fast_full_duplex;
				rd_next[`MSL_SET_AFHD] = adv_fast_half_duplex;
				rd_next[`MSL_SET_ATFD] = adv_ten_full_duplex;
				rd_next[`MSL_SET_ATHD] = adv_ten_half_duplex;
				rd_next[`MSL_SET_MULTI] = multi_port;
			end
			`MSL_OFS_CONTROL: begin
				rd_next[`MSL_CTL_PWRDN] = pd_fwd;
			end
			default: begin
				rd_next = 32'h00000000;
			end
		endcase
	end

	// The slave never inserts wait states, so hreadyout stays high.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= {ADDR_W{1'b0}};
			hrdata <= `MSL_HRDATA_RST;
			hreadyout <= `MSL_HREADY_RST;
			hresp <= `MSL_HRESP_OKAY;
		end else if (ce) begin
			hreadyout <= `MSL_HREADY_RST;
			hresp <= `MSL_HRESP_OKAY;
			if (hready) begin
				wr_pend_reg <= addr_take & hwrite & (hsize == `MSL_HSIZE_WORD) & (haddr[1:0] == 2'h0);
				wr_addr_reg <= haddr[ADDR_W-1:0];
				if (addr_take && !hwrite) begin
					hrdata <= rd_next;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Strap capture and held configuration.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			config_valid <= `MSL_VALID_RST;
		end else if (ce) begin
			if (!prst_s2_reg) begin
				config_valid <= 1'b0;
			end else if (release_pulse) begin
				config_valid <= 1'b1;
			end
		end
	end

	// Values change only at a release; they stay put through later pin resets until the next one.
	reg [`MSL_MODE_W-1:0] mode_code_next;
	reg mode_unsupported_next;
	reg pll_enable_next;
	reg autoneg_enable_next;
	reg auto_crossover_next;
	reg energy_efficient_operation_next;
	reg forced_gig_full_duplex_next;
	reg forced_fast_full_duplex_next;
	reg forced_master_next;
	reg adv_gig_full_duplex_next;
	reg adv_gig_half_duplex_next;
	reg adv_fast_full_duplex_next;
	reg adv_fast_half_duplex_next;
	reg adv_ten_full_duplex_next;
	reg adv_ten_half_duplex_next;
	reg multi_port_next;

	always @* begin
		mode_code_next = mode_code;
		mode_unsupported_next = mode_unsupported;
		pll_enable_next = pll_enable;
		autoneg_enable_next = autoneg_enable;
		auto_crossover_next = auto_crossover;
		energy_efficient_operation_next = energy_efficient_operation;
		forced_gig_full_duplex_next = forced_gig_full_duplex;
		forced_fast_full_duplex_next = forced_fast_full_duplex;
		forced_master_next = forced_master;
		adv_gig_full_duplex_next = adv_gig_full_duplex;
		adv_gig_half_duplex_next = adv_gig_half_duplex;
		adv_fast_full_duplex_next = adv_fast_full_duplex;
		adv_fast_half_duplex_next = adv_fast_half_duplex;
		adv_ten_full_duplex_next = adv_ten_full_duplex;
		adv_ten_half_duplex_next = adv_ten_half_duplex;
		multi_port_next = multi_port;
		if (release_pulse) begin
			mode_code_next = strap_s2_reg;
			mode_unsupported_next = dec_unsup;
			pll_enable_next = dec_pll;
			autoneg_enable_next = dec_an;
			auto_crossover_next = dec_xover;
			energy_efficient_operation_next = dec_eee;
			forced_gig_full_duplex_next = dec_fgig;
			forced_fast_full_duplex_next = dec_ffast;
			forced_master_next = dec_master;
			adv_gig_full_duplex_next = dec_agfd;
			adv_gig_half_duplex_next = dec_aghd;
			adv_fast_full_duplex_next = dec_affd;
			adv_fast_half_duplex_next = dec_afhd;
			adv_ten_full_duplex_next = dec_atfd;
			adv_ten_half_duplex_next = dec_athd;
			multi_port_next = dec_multi;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_code <= `MSL_MODE_RST;
			mode_unsupported <= `MSL_SET_RST;
			pll_enable <= `MSL_SET_RST;
			autoneg_enable <= `MSL_SET_RST;
			auto_crossover <= `MSL_SET_RST;
			energy_efficient_operation <= `MSL_SET_RST;
			forced_gig_full_duplex <= `MSL_SET_RST;
			forced_fast_full_duplex <= `MSL_SET_RST;
			forced_master <= `MSL_SET_RST;
			adv_gig_full_duplex <= `MSL_SET_RST;
			adv_gig_half_duplex <= `MSL_SET_RST;
			adv_fast_full_duplex <= `MSL_SET_RST;
			adv_fast_half_duplex <= `MSL_SET_RST;
			adv_ten_full_duplex <= `MSL_SET_RST;
			adv_ten_half_duplex <= `MSL_SET_RST;
			multi_port <= `MSL_SET_RST;
		end else if (ce) begin
			mode_code <= mode_code_next;
			mode_unsupported <= mode_unsupported_next;
			pll_enable <= pll_enable_next;
			autoneg_enable <= autoneg_enable_next;
			auto_crossover <= auto_crossover_next;
			energy_efficient_operation <= energy_efficient_operation_next;
			forced_gig_full_duplex <= forced_gig_full_duplex_next;
			forced_fast_full_duplex <= forced_fast_full_duplex_next;
			forced_master <= forced_master_next;
			adv_gig_full_duplex <= adv_gig_full_duplex_next;
			adv_gig_half_duplex <= adv_gig_half_duplex_next;
			adv_fast_full_duplex <= adv_fast_full_duplex_next;
			adv_fast_half_duplex <= adv_fast_half_duplex_next;
			adv_ten_full_duplex <= adv_ten_full_duplex_next;
			adv_ten_half_duplex <= adv_ten_half_duplex_next;
			multi_port <= multi_port_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power-down control: loaded from the strap at release, then owned by software.
	// A release in the same cycle as a software write wins, so the strap is never lost.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_power_down <= `MSL_CTL_RST;
		end else if (ce) begin
			if (release_pulse) begin
				sw_power_down <= dec_pd;
			end else if (wr_ctrl) begin
				sw_power_down <= hwdata[`MSL_CTL_PWRDN];
			end
		end
	end

endmodule

// ==== design/msl_consts.vh ====
`ifndef MSL_CONSTS_VH
`define MSL_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Strap field and mode codes.
`define MSL_MODE_W 5
`define MSL_MODE_RST 5'h00
`define MSL_MODE_PWRDN 5'h08
`define MSL_MODE_FORCE_GIG 5'h0A
`define MSL_MODE_FORCE_FAST 5'h0B
`define MSL_MODE_AN_SINGLE 5'h18
`define MSL_MODE_AN_MULTI 5'h19
`define MSL_MODE_AN_RSVD 5'h1E

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define MSL_OFS_STATUS 8'h00
`define MSL_OFS_SETTINGS 8'h04
`define MSL_OFS_CONTROL 8'h08

////////////////////////////////////////////////////////////////////////////////
// Status register fields.
`define MSL_STS_MODE_LSB 0
`define MSL_STS_VALID 8
`define MSL_STS_UNSUP 9
`define MSL_STS_PINRST 10

////////////////////////////////////////////////////////////////////////////////
// Settings register fields.
`define MSL_SET_PLL 0
`define MSL_SET_AN 1
`define MSL_SET_XOVER 2
`define MSL_SET_EEE 3
`define MSL_SET_FGIG 4
`define MSL_SET_FFAST 5
`define MSL_SET_MASTER 6
`define MSL_SET_AGFD 7
`define MSL_SET_AGHD 8
`define MSL_SET_AFFD 9
`define MSL_SET_AFHD 10
`define MSL_SET_ATFD 11
`define MSL_SET_ATHD 12
`define MSL_SET_MULTI 13

////////////////////////////////////////////////////////////////////////////////
// Control register fields and reset values.
`define MSL_CTL_PWRDN 0
`define MSL_CTL_RST 1'b0
`define MSL_SET_RST 1'b0
`define MSL_VALID_RST 1'b0

////////////////////////////////////////////////////////////////////////////////
// Bus encodings.
`define MSL_HSIZE_WORD 3'h2
`define MSL_HRESP_OKAY 1'b0
`define MSL_HREADY_RST 1'b1
`define MSL_HRDATA_RST 32'h00000000

`endif

// ==== design/msl_mode_decode.v ====
`timescale 1ns/100ps
`include "msl_consts.vh"

module msl_mode_decode (
	input wire [`MSL_MODE_W-1:0] mode_code,
	output reg power_down,
	output reg pll_enable,
	output reg autoneg_enable,
	output reg auto_crossover,
	output reg energy_efficient_operation,
	output reg forced_gig_full_duplex,
	output reg forced_fast_full_duplex,
	output reg forced_master,
	output reg adv_gig_full_duplex,
	output reg adv_gig_half_duplex,
	output reg adv_fast_full_duplex,
	output reg adv_fast_half_duplex,
	output reg adv_ten_full_duplex,
	output reg adv_ten_half_duplex,
	output reg multi_port,
	output reg unsupported
);

	////////////////////////////////////////////////////////////////////////////////
	// One code selects one mode for every port.
	always @* begin
		power_down = 1'b0;
		pll_enable = 1'b1;
		autoneg_enable = 1'b0;
		auto_crossover = 1'b0;
		energy_efficient_operation = 1'b0;
		forced_gig_full_duplex = 1'b0;
		forced_fast_full_duplex = 1'b0;
		forced_master = 1'b0;
		adv_gig_full_duplex = 1'b0;
		adv_gig_half_duplex = 1'b0;
		adv_fast_full_duplex = 1'b0;
		adv_fast_half_duplex = 1'b0;
		adv_ten_full_duplex = 1'b0;
		adv_ten_half_duplex = 1'b0;
		multi_port = 1'b0;
		unsupported = 1'b0;
		case (mode_code)
			`MSL_MODE_PWRDN: begin
				power_down = 1'b1;
			end
			`MSL_MODE_FORCE_GIG: begin
				forced_gig_full_duplex = 1'b1;
				forced_master = 1'b1;
			end
			`MSL_MODE_FORCE_FAST: begin
				forced_fast_full_duplex = 1'b1;
			end
			`MSL_MODE_AN_SINGLE, `MSL_MODE_AN_MULTI: begin
				autoneg_enable = 1'b1;
				auto_crossover = 1'b1;
				energy_efficient_operation = 1'b1;
				adv_gig_full_duplex = 1'b1;
				adv_fast_full_duplex = 1'b1;
				adv_fast_half_duplex = 1'b1;
				adv_ten_full_duplex = 1'b1;
				adv_ten_half_duplex = 1'b1;
				multi_port = mode_code[0];
			end
			default: begin
				// Other high codes except MSL_MODE_AN_RSVD negotiate broadly; MSL_MODE_AN_RSVD and low reserved codes park the ports powered down.
				if (mode_code[4] && (mode_code != `MSL_MODE_AN_RSVD)) begin
					autoneg_enable = 1'b1;
					auto_crossover = 1'b1;
					energy_efficient_operation = mode_code[3];
					adv_gig_full_duplex = 1'b1;
					adv_fast_full_duplex = 1'b1;
					adv_fast_half_duplex = 1'b1;
					adv_ten_full_duplex = 1'b1;
					adv_ten_half_duplex = 1'b1;
					multi_port = mode_code[0];
				end else begin
					power_down = 1'b1;
					unsupported = 1'b1;
				end
			end
		endcase
	end

endmodule

// ==== testbench/msl_strap_board.sv ====
`timescale 1ns/100ps
`include "msl_consts.vh"

module msl_strap_board (
	input logic [`MSL_MODE_W-1:0] code,
	output wire [`MSL_MODE_W-1:0] mode_strap
);
	// Every strap line is driven straight from code, so each line is a steady level and is never left floating.
	assign mode_strap = code;
endmodule

// ==== testbench/msl_strap_checker_assertions.sv ====
`timescale 1ns/100ps
`include "msl_consts.vh"

module msl_strap_checker (
	input wire hclk,
	input wire hresetn,
	input wire pin_reset_n,
	input wire [`MSL_MODE_W-1:0] mode_strap,
	input wire [`MSL_MODE_W-1:0] mode_code,
	input wire config_valid,
	input wire sw_power_down,
	input wire pll_enable,
	input wire autoneg_enable,
	input wire auto_crossover,
	input wire energy_efficient_operation,
	input wire forced_gig_full_duplex,
	input wire forced_fast_full_duplex,
	input wire forced_master,
	input wire adv_gig_half_duplex
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire no_neg = !autoneg_enable && !auto_crossover && !energy_efficient_operation;

	a_capture_on_release: assert property ($rose(config_valid) |-> mode_code == $past(mode_strap, 3))
		else $error("Latched code differs from strap level.");
	a_release_latency: assert property ($rose(pin_reset_n) |-> ##[2:4] config_valid)
		else $error("No capture after pin reset release.");
	a_code_held: assert property (config_valid && $past(config_valid) |-> $stable(mode_code))
		else $error("Latched code moved without a release.");
	a_one_forced: assert property (!(forced_gig_full_duplex && forced_fast_full_duplex))
		else $error("Two forced modes at once.");
	a_pwrdn_pll: assert property ($rose(config_valid) && mode_code == `MSL_MODE_PWRDN
		|-> sw_power_down && pll_enable)
		else $error("Power-down code without power-down and PLL.");
	a_gig_forced: assert property (config_valid && mode_code == `MSL_MODE_FORCE_GIG
		|-> forced_gig_full_duplex && forced_master && no_neg)
		else $error("Forced gigabit decode wrong.");
	a_fast_forced: assert property (config_valid && mode_code == `MSL_MODE_FORCE_FAST
		|-> forced_fast_full_duplex && !forced_master && no_neg)
		else $error("Forced fast decode wrong.");
	a_gig_half_off: assert property (!adv_gig_half_duplex)
		else $error("Gigabit half duplex advertised.");
endmodule

bind msl_strap_loader msl_strap_checker u_chk (.hclk, .hresetn, .pin_reset_n, .mode_strap, .mode_code,
	.config_valid, .sw_power_down, .pll_enable, .autoneg_enable, .auto_crossover, .energy_efficient_operation,
	.forced_gig_full_duplex, .forced_fast_full_duplex, .forced_master, .adv_gig_half_duplex);

// ==== testbench/mode_strap_latch_decode_tb.sv ====
`timescale 1ns/100ps
`include "msl_consts.vh"

module mode_strap_latch_decode_tb;
	logic hclk, hresetn, hsel, hwrite, pin_reset_n, rd_ph, prev_uns;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, seed;
	logic [4:0] code, prev_code;
	logic [4:0] codes [8] = '{5'h08, 5'h0A, 5'h0B, 5'h18, 5'h19, 5'h09, 5'h03, 5'h1E};
	wire hreadyout, hresp, config_valid;
	wire [31:0] hrdata;
	wire [4:0] mode_strap;
	logic [31:0] exp_q[$];
	string nm_q[$];
	int error_cnt, num_checks;

	msl_strap_loader dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(`MSL_HSIZE_WORD),
		.hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pin_reset_n, .mode_strap, .mode_code(),
		.config_valid, .mode_unsupported(), .sw_power_down(), .pll_enable(), .autoneg_enable(), .auto_crossover(),
		.energy_efficient_operation(), .forced_gig_full_duplex(), .forced_fast_full_duplex(), .forced_master(),
		.adv_gig_full_duplex(), .adv_gig_half_duplex(), .adv_fast_full_duplex(), .adv_fast_half_duplex(),
		.adv_ten_full_duplex(), .adv_ten_half_duplex(), .multi_port());
	msl_strap_board board (.code, .mode_strap);

	initial begin
		hclk = 0;
		forever #5 hclk = ~hclk;
	end

	// Read data is judged at the edge that closes the data phase, against the oldest noted expectation.
	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1) begin
			chk(nm_q.pop_front(), hrdata, exp_q.pop_front());
			chk("hresp", {31'h0, hresp}, 32'h0);
		end
		rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic uns(input logic [4:0] c);
		return c < 5'h08 || c == 5'h09 || (c > 5'h0B && c < 5'h10) || c == 5'h1E;
	endfunction

	function automatic logic [31:0] exp_set(input logic [4:0] c);
		if (uns(c) || c == 5'h08)
			return 32'h1;
		if (c == 5'h0A)
			return 32'h51;
		if (c == 5'h0B)
			return 32'h21;
		return 32'h1E87 | {18'h0, c[0], 9'h0, c[3], 3'h0};
	endfunction

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wait_hi(input logic sel);
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while ((sel ? config_valid : hreadyout) !== 1'b1 && n < 50);
		if ((sel ? config_valid : hreadyout) !== 1'b1) begin
			error_cnt++;
			close_out();
		end
	endtask

	// For a read, d is the expected word.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input string nm);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		wait_hi(0);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		if (!w) begin
			exp_q.push_back(d);
			nm_q.push_back(nm);
		end
		wait_hi(0);
	endtask

	// The strap is set up well before release, since a late strap could be caught half-changed.
	task automatic strap(input logic [4:0] c);
		@(posedge hclk);
		code <= c;
		pin_reset_n <= 1'b0;
		repeat (3) @(posedge hclk);
		bus(0, `MSL_OFS_STATUS, {22'h0, prev_uns, 4'h0, prev_code}, "status in reset");
		pin_reset_n <= 1'b1;
		wait_hi(1);
		prev_code = c;
		prev_uns = uns(c);
	endtask

	initial begin
		hresetn = 0;
		hsel = 0;
		hwrite = 0;
		htrans = 0;
		haddr = 0;
		hwdata = 0;
		pin_reset_n = 0;
		code = 0;
		prev_code = 0;
		prev_uns = 0;
		seed = 32'hE625;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (codes[i]) begin
			strap(codes[i]);
			bus(0, `MSL_OFS_STATUS, {22'h1, uns(codes[i]), 1'b1, 3'h0, codes[i]}, "status");
			bus(0, `MSL_OFS_SETTINGS, exp_set(codes[i]), "settings");
			bus(0, `MSL_OFS_CONTROL, {31'h0, uns(codes[i]) || codes[i] == 5'h08}, "power down");
			$display("mode %h done", codes[i]);
		end
		code <= 5'h18;
		repeat (4) begin
			seed = lfsr(seed);
			bus(1, `MSL_OFS_CONTROL, seed, "");
			bus(1, `MSL_OFS_STATUS, ~seed, "");
			bus(0, `MSL_OFS_CONTROL, {31'h0, seed[0]}, "control");
			bus(0, {24'h0, seed[7:2], 2'h0} | 32'h10, 32'h0, "unmapped");
		end
		bus(0, `MSL_OFS_STATUS, {22'h1, 1'b1, 1'b1, 3'h0, 5'h1E}, "held code");
		$display("bus and hold done");
		repeat (3) @(posedge hclk);
		close_out();
	end
endmodule
